// ### rtl/ldf_deframer_rx.sv
// Receive end: local multiframe clocks, latency readback, release buffer
// and sample unpacking, with a Wishbone register slave.
// Assumes the transmitter and the bus master share ref_clk.
`timescale 1ns/10ps
`default_nettype none
module ldf_deframer_rx
  import ldf_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   srst,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [13:0]            wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  // Link
  ldf_link_if.rx                      link,
  // Converter samples per link
  output logic [1:0][SampleW-1:0]     sampleFirst,
  output logic [1:0][SampleW-1:0]     sampleSecond,
  output logic [1:0]                  sampleValid,
  output logic [1:0]                  lmfcRxEdge
);
  logic [31:0]      cfg_reg;
  logic [1:0][7:0]  delay_reg;
  logic [1:0][7:0]  budget_reg;
  logic [7:0]       status_reg;
  logic [5:0]       frameCnt_reg;
  logic             ack_reg;
  logic [31:0]      rdData_reg;

  wire [3:0] cfgLanes = cfg_reg[CfgLanesLsb +: 4];
  wire [2:0] cfgConv  = cfg_reg[CfgConvLsb +: 3];
  wire [2:0] cfgOct   = cfg_reg[CfgOctLsb +: 3];
  wire [1:0] cfgSamp  = cfg_reg[CfgSampLsb +: 2];
  wire [5:0] cfgK     = cfg_reg[CfgKLsb +: 6];
  wire       cfgHd    = cfg_reg[CfgHdBit];
  wire       cfgDual  = cfg_reg[CfgDualBit];
  wire       cfgEn    = cfg_reg[CfgEnBit];

  wire [3:0] fpp   = framesPerPclk(cfgOct);
  wire [5:0] pcpmf = pclksPerMf(cfgK, cfgOct);

  // Configuration checks, recomputed every cycle
  wire octOk   = (cfgOct == 3'h1) || (cfgOct == 3'h2) ||
                 (cfgOct == 3'h4);
  wire sampOk  = (cfgSamp == 2'h1) || (cfgSamp == 2'h2);
  wire lanesOk = (cfgLanes == 4'h1) || (cfgLanes == 4'h2) ||
                 (cfgLanes == 4'h4) ||
                 (!cfgDual && cfgLanes == 4'h8);
  wire convOk  = (cfgConv == 3'h1) || (cfgConv == 3'h2) ||
                 (!cfgDual && cfgConv == 3'h4);
  wire ctrlOk  = !cfg_reg[CfgCfBit] && !cfg_reg[CfgCsBit];
  wire hdOk    = (cfgHd == (cfgOct == 3'h1));
  wire comboBad = !(octOk && sampOk && lanesOk && convOk &&
                    ctrlOk && hdOk);
  wire kBad    = !((cfgK == 6'h20) ||
                   (cfgK == 6'h10 && cfgOct != 3'h1));
  wire delayBad = (delay_reg[0] >= {2'h0, cfgK}) ||
                  (cfgDual && delay_reg[1] >= {2'h0, cfgK});
  wire cfgGood = cfgEn && !comboBad && !kBad && !delayBad;

  // Shared SYSREF-aligned frame counter, advancing 4/F frames per cycle
  wire [6:0] frameSum = {1'b0, frameCnt_reg} + {3'h0, fpp};
  wire [6:0] frameWrap = (frameSum >= {1'b0, cfgK}) ?
                         frameSum - {1'b0, cfgK} : frameSum;

  always_ff @(posedge ref_clk) begin
    if (srst || link.sysrefPulse) begin
      frameCnt_reg <= '0;
    end else begin
      frameCnt_reg <= frameWrap[5:0];
    end
  end

  // Register slave: one wait state, ack drops the cycle after it rises
  wire [11:0] regIdx = wb_adr_i[13:2];
  wire        wbReq  = wb_cyc_i && wb_stb_i && !ack_reg;
  wire        wbWr   = wbReq && wb_we_i;
  wire [1:0][7:0] budgetEff;
  wire [1:0][5:0] latency;

  wire [31:0] readMux =
    (regIdx == IdxStatus) ? {24'h0, status_reg} :
    (regIdx == IdxLat0)   ? {26'h0, latency[0]} :
    (regIdx == IdxLat1)   ? {26'h0, latency[1]} :
    (regIdx == IdxDelA)   ? {24'h0, delay_reg[0]} :
    (regIdx == IdxDelB)   ? {24'h0, delay_reg[1]} :
    (regIdx == IdxVarA)   ? {24'h0, budget_reg[0]} :
    (regIdx == IdxVarB)   ? {24'h0, budget_reg[1]} :
    (regIdx == IdxConfig) ? cfg_reg : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_reg    <= 1'b0;
      rdData_reg <= '0;
      status_reg <= '0;
      cfg_reg    <= CfgReset;
      delay_reg  <= {DelayReset, DelayReset};
      budget_reg <= {BudgetReset, BudgetReset};
    end else begin
      ack_reg    <= wbReq;
      status_reg <= {2'h0, delayBad, 1'b0, comboBad, kBad, 2'h0};
      if (wbReq) begin
        rdData_reg <= readMux;
      end
      if (wbWr && wb_sel_i[0]) begin
        // Each copy applies to its own link
        if (regIdx == IdxDelA) delay_reg[0] <= wb_dat_i[7:0];
        if (regIdx == IdxDelB) delay_reg[1] <= wb_dat_i[7:0];
        if (regIdx == IdxVarA) budget_reg[0] <= wb_dat_i[7:0];
        if (regIdx == IdxVarB) budget_reg[1] <= wb_dat_i[7:0];
      end
      if (wbWr && regIdx == IdxConfig) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) cfg_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  for (genvar l = 0; l < NumLinks; l++) begin : g_link
    ldf_rx_state_t state_reg;
    ldf_rx_state_t state_next;
    logic [5:0] lat_reg;
    logic [5:0] latCnt_reg;
    logic [3:0] hold_reg;
    logic [WordW-1:0] bufData;
    logic bufValid;

    wire active = cfgGood && (l == 0 || cfgDual);
    // Budgets above the buffer's reach are held at the top setting
    assign budgetEff[l] = (budget_reg[l] > MaxBudget) ?
                          MaxBudget : budget_reg[l];

    // Local multiframe phase lags the aligned one by the frame delay
    wire [6:0] phSum = {1'b0, frameCnt_reg} + {1'b0, cfgK} -
                       {1'b0, delay_reg[l][5:0]};
    wire [6:0] phase = (phSum >= {1'b0, cfgK}) ?
                       phSum - {1'b0, cfgK} : phSum;
    wire edgeNow = active && (phase < {3'h0, fpp});
    wire firstData = link.laneValid[l] && !link.ilasActive[l];
    wire [5:0] latInc = latCnt_reg + 6'h01;

    assign lmfcRxEdge[l] = edgeNow;
    assign latency[l]    = lat_reg;
    assign link.syncRequestN[l] = (state_reg != RxIdle);

    always_comb begin
      state_next = state_reg;
      unique case (state_reg)
        RxIdle:   if (active) state_next = RxAlign;
        RxAlign:  if (firstData) state_next = RxArrive;
        RxArrive: if (edgeNow) state_next = RxHold;
        RxHold:   if (hold_reg == budgetEff[l][3:0])
                    state_next = RxStream;
        RxStream: state_next = RxStream;
        default:  state_next = RxIdle;
      endcase
      if (!active) state_next = RxIdle;
    end

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        state_reg  <= RxIdle;
        lat_reg    <= '0;
        latCnt_reg <= '0;
        hold_reg   <= '0;
      end else begin
        state_reg <= state_next;
        // Cycles since the local edge, wrapping each multiframe
        latCnt_reg <= (edgeNow || latInc >= pcpmf) ? 6'h00 : latInc;
        // A data transition on the edge itself counts as zero delay
        if (state_reg == RxAlign && firstData) begin
          lat_reg <= edgeNow ? 6'h00 : latInc;
        end
        hold_reg <= (state_reg == RxHold) ? hold_reg + 4'h1 : 4'h0;
      end
    end

    ldf_release_buffer u_buf (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clear    (state_reg == RxIdle),
      .wrValid  (link.laneValid[l] && !link.ilasActive[l] &&
                 state_reg != RxIdle),
      .wrData   (link.laneWord[l]),
      .rdEnable (state_reg == RxStream),
      .rdData   (bufData),
      .rdValid  (bufValid)
    );

    // First octet is the most significant; 16-bit samples
    assign sampleFirst[l]  = bufData[31:16];
    assign sampleSecond[l] = bufData[15:0];
    assign sampleValid[l]  = bufValid;
  end
endmodule // ldf_deframer_rx
`default_nettype wire

// ### rtl/ldf_pkg.sv
// Shared constants, types and helpers for the link delay deframer pair.
// Assumes one 250 MHz parallel clock drives both ends of the link.
package ldf_pkg;
  localparam int NumLinks = 2;
  localparam int WordW    = 32;
  localparam int SampleW  = 16;
  localparam int BufAw    = 6;
  localparam int BufDepth = 64;

  // Register indices; byte address on the bus is four times the index
  localparam logic [11:0] IdxStatus = 12'h030;
  localparam logic [11:0] IdxLat0   = 12'h302;
  localparam logic [11:0] IdxLat1   = 12'h303;
  localparam logic [11:0] IdxDelA   = 12'h304;
  localparam logic [11:0] IdxDelB   = 12'h305;
  localparam logic [11:0] IdxVarA   = 12'h306;
  localparam logic [11:0] IdxVarB   = 12'h307;
  localparam logic [11:0] IdxConfig = 12'h310;

  // Configuration register fields
  localparam int CfgLanesLsb = 0;
  localparam int CfgConvLsb  = 4;
  localparam int CfgOctLsb   = 8;
  localparam int CfgSampLsb  = 12;
  localparam int CfgKLsb     = 16;
  localparam int CfgHdBit    = 24;
  localparam int CfgDualBit  = 25;
  localparam int CfgCfBit    = 26;
  localparam int CfgCsBit    = 27;
  localparam int CfgEnBit    = 28;
  localparam logic [31:0] CfgReset = 32'h0120_1124;

  // Configuration check flags
  localparam int StatKBit     = 2;
  localparam int StatComboBit = 3;
  localparam int StatDelayBit = 5;

  localparam logic [7:0] DelayReset  = 8'h00;
  localparam logic [7:0] BudgetReset = 8'h00;
  localparam logic [7:0] MaxBudget   = 8'h0a;
  localparam logic [3:0] FramesPerPclkNum = 4'h4;
  localparam logic [2:0] IlasMultiframes  = 3'h4;
  localparam logic [31:0] IlasFill  = 32'h1c1c_1c1c;

  typedef enum logic [2:0] {
    RxIdle = 3'b000, RxAlign = 3'b001, RxArrive = 3'b011,
    RxHold = 3'b010, RxStream = 3'b110
  } ldf_rx_state_t;

  typedef enum logic [1:0] {
    TxSync = 2'b00, TxWait = 2'b01, TxIlas = 2'b11, TxData = 2'b10
  } ldf_tx_state_t;

  // Frame clock cycles per parallel clock cycle, 4/F
  function automatic logic [3:0] framesPerPclk(input logic [2:0] f);
    return FramesPerPclkNum / {1'b0, f};
  endfunction

  // Parallel clock cycles per multiframe, K*F/4
  function automatic logic [5:0] pclksPerMf(input logic [5:0] k,
                                            input logic [2:0] f);
    logic [8:0] p;
    p = {3'h0, k} * {6'h00, f};
    return p[7:2];
  endfunction
endpackage

// ### rtl/ldf_link_if.sv
// Parallel-clock link between the transmitter and the deframer.
// Assumes both ends run on ref_clk; no crossing is needed.
`timescale 1ns/10ps
`default_nettype none
interface ldf_link_if (
  input wire logic ref_clk
);
  logic                  sysrefPulse;
  logic [1:0]            syncRequestN;
  logic [1:0][31:0]      laneWord;
  logic [1:0]            laneValid;
  logic [1:0]            ilasActive;

  modport tx (
    input  ref_clk, syncRequestN,
    output sysrefPulse, laneWord, laneValid, ilasActive
  );
  modport rx (
    input  ref_clk, sysrefPulse, laneWord, laneValid, ilasActive,
    output syncRequestN
  );
endinterface
`default_nettype wire

// ### rtl/ldf_release_buffer.sv
// Receive buffer holding link words until the release point.
// Assumes the reader starts at most one multiframe plus budget later.
`timescale 1ns/10ps
`default_nettype none
module ldf_release_buffer
  import ldf_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              clear,
  // Write side
  input  wire logic              wrValid,
  input  wire logic [WordW-1:0]  wrData,
  // Read side
  input  wire logic              rdEnable,
  output logic [WordW-1:0]       rdData,
  output logic                   rdValid
);
  logic [WordW-1:0] mem [BufDepth];
  logic [BufAw:0]   wrPtr_reg;
  logic [BufAw:0]   rdPtr_reg;

  wire empty = (wrPtr_reg == rdPtr_reg);
  wire full  = (wrPtr_reg[BufAw] != rdPtr_reg[BufAw]) &&
               (wrPtr_reg[BufAw-1:0] == rdPtr_reg[BufAw-1:0]);
  wire doWr  = wrValid && !full;
  wire doRd  = rdEnable && !empty;

  always_ff @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr_reg[BufAw-1:0]] <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || clear) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      rdData    <= '0;
      rdValid   <= 1'b0;
    end else begin
      wrPtr_reg <= wrPtr_reg + {6'h00, doWr};
      rdPtr_reg <= rdPtr_reg + {6'h00, doRd};
      rdValid   <= doRd;
      if (doRd) begin
        rdData <= mem[rdPtr_reg[BufAw-1:0]];
      end
    end
  end
endmodule // ldf_release_buffer
`default_nettype wire

// ### rtl/ldf_link_tx.sv
// Transmit end: SYSREF-aligned multiframe counter, sync handling,
// ILAS then user data per link, and delay setting arithmetic.
// Assumes the user keeps its word stable while txReady is low.
`timescale 1ns/10ps
`default_nettype none
module ldf_link_tx
  import ldf_pkg::*;
(
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                srst,
  // Link parameters, shared with the receive end
  input  wire logic [2:0]          octetsPerFrame,
  input  wire logic [5:0]          framesPerMf,
  // User data per link
  input  wire logic [1:0][31:0]    txWord,
  output logic [1:0]               txReady,
  // Delay setting helper
  input  wire logic [7:0]          minObservedDelay,
  input  wire logic [7:0]          maxObservedDelay,
  output logic [7:0]               frameDelaySetting,
  output logic [7:0]               budgetSetting,
  // Link
  ldf_link_if.tx                   link
);
  logic [5:0] mfCnt_reg;
  wire  [5:0] pcpmf   = pclksPerMf(framesPerMf, octetsPerFrame);
  wire  [3:0] fpp     = framesPerPclk(octetsPerFrame);
  wire  [5:0] mfInc   = mfCnt_reg + 6'h01;
  wire        mfStart = (mfCnt_reg == 6'h00);

  // Setting arithmetic for software's sake
  wire [7:0]  minLess = minObservedDelay - 8'h01;
  wire [11:0] delProd = {4'h0, minLess} * {8'h00, fpp};
  wire [11:0] delMod  = delProd % {6'h00, framesPerMf};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mfCnt_reg         <= '0;
      frameDelaySetting <= '0;
      budgetSetting     <= '0;
    end else begin
      mfCnt_reg <= (mfInc >= pcpmf) ? 6'h00 : mfInc;
      budgetSetting     <= (maxObservedDelay + 8'h01) - minLess;
      frameDelaySetting <= delMod[7:0];
    end
  end

  assign link.sysrefPulse = !srst && mfStart;

  for (genvar l = 0; l < NumLinks; l++) begin : g_link
    ldf_tx_state_t state_reg;
    logic [8:0]  ilasCnt_reg;
    logic [31:0] word_reg;
    logic        valid_reg;
    logic        ilas_reg;
    wire  [8:0]  ilasLen = {3'h0, pcpmf} * {6'h00, IlasMultiframes};
    wire         synced  = link.syncRequestN[l];

    // Ready already in the last alignment cycle, where the first word loads
    wire         ilasDone = (state_reg == TxIlas) && (ilasCnt_reg >= ilasLen);
    assign txReady[l] = ((state_reg == TxData) || ilasDone) && synced;
    assign link.laneWord[l]   = word_reg;
    assign link.laneValid[l]  = valid_reg;
    assign link.ilasActive[l] = ilas_reg;

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        state_reg   <= TxSync;
        ilasCnt_reg <= '0;
        word_reg    <= '0;
        valid_reg   <= 1'b0;
        ilas_reg    <= 1'b0;
      end else if (!synced) begin
        state_reg <= TxSync;
        valid_reg <= 1'b0;
        ilas_reg  <= 1'b0;
      end else begin
        unique case (state_reg)
          TxSync: state_reg <= TxWait;
          TxWait: begin
            // ILAS begins on a multiframe boundary
            if (mfStart) begin
              state_reg   <= TxIlas;
              ilasCnt_reg <= 9'h001;
              word_reg    <= IlasFill;
              valid_reg   <= 1'b1;
              ilas_reg    <= 1'b1;
            end
          end
          TxIlas: begin
            ilasCnt_reg <= ilasCnt_reg + 9'h001;
            if (ilasCnt_reg >= ilasLen) begin
              state_reg <= TxData;
              word_reg  <= txWord[l];
              ilas_reg  <= 1'b0;
            end
          end
          TxData: word_reg <= txWord[l];
        endcase
      end
    end
  end
endmodule // ldf_link_tx
`default_nettype wire

// ### tb/ldf_checker.sv
// Link-side assertions for the deframer pair, on link 0.
// Assumes every legal mode gives at least 8 cycles per multiframe.
`timescale 1ns/10ps
`default_nettype none
module ldf_checker
  import ldf_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             srst,
  // Link signals
  input wire logic             sysrefPulse,
  input wire logic [1:0]       syncRequestN,
  input wire logic [1:0][31:0] laneWord,
  input wire logic [1:0]       laneValid,
  input wire logic [1:0]       ilasActive
);
  logic [2:0] mfCnt_reg;
  wire        dataPhase = laneValid[0] && !ilasActive[0];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Multiframe boundaries seen while alignment words are on the lane
  always_ff @(posedge ref_clk) begin
    if (srst || !ilasActive[0])
      mfCnt_reg <= 3'h0;
    else if (sysrefPulse)
      mfCnt_reg <= mfCnt_reg + 3'h1;
  end

  sequence s_ilas_start;
    $rose(ilasActive[0]);
  endsequence
  sequence s_data_start;
    $fell(ilasActive[0]) && laneValid[0];
  endsequence

  property p_ilas_fill;
    ilasActive[0] |-> laneValid[0] && laneWord[0] == IlasFill;
  endproperty
  a_ilas_fill: assert property (p_ilas_fill)
    else $error("alignment word wrong or not valid");
  property p_ilas_start;
    s_ilas_start |-> $past(sysrefPulse) && !$past(laneValid[0]);
  endproperty
  a_ilas_start: assert property (p_ilas_start)
    else $error("alignment started off a multiframe boundary");
  property p_ilas_len;
    s_data_start |-> mfCnt_reg == IlasMultiframes;
  endproperty
  a_ilas_len: assert property (p_ilas_len)
    else $error("alignment length wrong");
  property p_data_edge;
    s_data_start |-> $past(sysrefPulse);
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("first data off a multiframe boundary");
  property p_sync_drop;
    !syncRequestN[0] |=> !laneValid[0];
  endproperty
  a_sync_drop: assert property (p_sync_drop)
    else $error("words still valid after sync request");
  property p_sync_ilas;
    $rose(syncRequestN[0]) |-> ##[1:40] ilasActive[0];
  endproperty
  a_sync_ilas: assert property (p_sync_ilas)
    else $error("no alignment after sync release");
  property p_mf_period;
    sysrefPulse |=> !sysrefPulse [*7] ##[1:25] sysrefPulse;
  endproperty
  a_mf_period: assert property (p_mf_period)
    else $error("multiframe period out of range");
  property p_data_moves;
    dataPhase && $past(dataPhase) |-> laneWord[0] != $past(laneWord[0]);
  endproperty
  a_data_moves: assert property (p_data_moves)
    else $error("data word repeated");
endmodule // ldf_checker
`default_nettype wire

// ### tb/tb.sv
// Bench joining transmit and deframer ends over one link instance.
// Assumes a 250 MHz ref_clk; registers reached over classic Wishbone.
`timescale 1ns/10ps
`default_nettype none
module tb
  import ldf_pkg::*;
;
  localparam int          Pcyc    = 8; // K*F/4 for K=32, F=1
  localparam logic [31:0] CfgDual = 32'h0320_1124;
  // Clock, reset and bus
  logic             ref_clk;
  logic             srst;
  logic             wbCyc;
  logic             wbStb;
  logic             wbWe;
  logic [13:0]      wbAdr;
  logic [3:0]       wbSel;
  logic [31:0]      wbDatW;
  logic [31:0]      wbDatR;
  logic             wbAck;
  // Samples and transmit side
  logic [1:0][15:0] sampleFirst;
  logic [1:0][15:0] sampleSecond;
  logic [1:0]       sampleValid;
  logic [1:0]       lmfcRxEdge;
  logic [2:0]       octetsPerFrame;
  logic [5:0]       framesPerMf;
  logic [1:0][31:0] txWord;
  logic [1:0]       txReady;
  logic [7:0]       minObs;
  logic [7:0]       maxObs;
  logic [7:0]       frameDelaySetting;
  logic [7:0]       budgetSetting;
  logic [7:0]       wordCnt;
  logic [31:0]      rdv;
  logic [31:0]      cfgTab [12];
  logic [7:0]       statTab [12];
  int               mismatches;
  int               nCompared;
  int               lat, h0, hN, o0, o1, p0, p1;

  ldf_link_if link (.ref_clk(ref_clk));
  ldf_deframer_rx i_ldf_deframer_rx (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .link(link),
    .sampleFirst(sampleFirst), .sampleSecond(sampleSecond),
    .sampleValid(sampleValid), .lmfcRxEdge(lmfcRxEdge));
  ldf_link_tx i_ldf_link_tx (
    .ref_clk(ref_clk), .srst(srst), .octetsPerFrame(octetsPerFrame),
    .framesPerMf(framesPerMf), .txWord(txWord), .txReady(txReady),
    .minObservedDelay(minObs), .maxObservedDelay(maxObs),
    .frameDelaySetting(frameDelaySetting), .budgetSetting(budgetSetting),
    .link(link));
  ldf_checker i_ldf_checker (
    .ref_clk(ref_clk), .srst(srst), .sysrefPulse(link.sysrefPulse),
    .syncRequestN(link.syncRequestN), .laneWord(link.laneWord),
    .laneValid(link.laneValid), .ilasActive(link.ilasActive));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Word count restarts outside the data phase, so the first word is known
  assign txWord = {2{8'ha0, wordCnt, 8'h50, wordCnt}};
  always @(posedge ref_clk)
    wordCnt <= txReady[0] ? wordCnt + 8'h01 : 8'h00;

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [11:0] idx,
                    input logic [3:0] sel, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    {wbCyc, wbStb, wbWe} <= {2'b11, we};
    {wbAdr, wbSel, wbDatW} <= {idx, 2'b00, sel, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatR;
    check({31'h0, wbAck}, 32'h1, "bus answer");
    {wbCyc, wbStb} <= 2'b00;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, idx, 4'hf, d, x);
  endtask

  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp,
                       input string what);
    logic [31:0] x;
    wb(1'b0, idx, 4'hf, 32'h0, x);
    check(x, exp, what);
  endtask

  task automatic helper(input logic [2:0] f, input logic [5:0] k,
                        input logic [7:0] mn, input logic [7:0] mx,
                        input logic [7:0] ed, input logic [7:0] eb);
    {octetsPerFrame, framesPerMf} <= {f, k};
    {minObs, maxObs} <= {mn, mx};
    repeat (3) @(posedge ref_clk);
    check({24'h0, frameDelaySetting}, {24'h0, ed}, "delay setting");
    check({24'h0, budgetSetting}, {24'h0, eb}, "budget setting");
  endtask

  // Host keeps both copies equal except where per-link delays are probed
  task automatic set_regs(input logic [7:0] da, input logic [7:0] db,
                          input logic [7:0] bud);
    wr(IdxDelA, {24'h0, da});
    wr(IdxDelB, {24'h0, db});
    wr(IdxVarA, {24'h0, bud});
    wr(IdxVarB, {24'h0, bud});
  endtask

  // Restart the link; measure latency to first data and release hold
  task automatic run_link(input bit twin, output int lt, output int hd);
    int n;
    wr(IdxConfig, CfgDual);
    wr(IdxConfig, CfgDual | 32'h1000_0000);
    lt = 0;
    n = 0;
    do begin
      @(posedge ref_clk);
      lt = (lmfcRxEdge[0] === 1'b1) ? 0 : lt + 1;
      n++;
    end while (!(link.laneValid[0] === 1'b1 &&
                 link.ilasActive[0] === 1'b0) && n < 300);
    check({31'h0, n < 300}, 32'h1, "no first data");
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (lmfcRxEdge[0] !== 1'b1 && n < 300);
    check({31'h0, n < 300}, 32'h1, "no local edge");
    hd = 0;
    do begin
      @(posedge ref_clk);
      hd++;
    end while (sampleValid[0] !== 1'b1 && hd < 300);
    check({sampleFirst[0], sampleSecond[0]}, 32'ha000_5000, "first");
    if (twin)
      check({sampleFirst[1], sampleSecond[1]}, 32'ha000_5000, "1st");
    @(posedge ref_clk);
    check({sampleFirst[0], sampleSecond[0]}, 32'ha001_5001, "next");
  endtask

  task automatic edge_off(input int l, output int off);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (link.sysrefPulse !== 1'b1 && n < 100);
    off = 0;
    while (lmfcRxEdge[l] !== 1'b1 && off < 100) begin
      @(posedge ref_clk);
      off++;
    end
  endtask

  task automatic final_report;
    if (mismatches == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    final_report;
  end

  initial begin
    {srst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = {4'h8, 50'h0};
    {octetsPerFrame, framesPerMf, minObs, maxObs} = {3'h1, 6'h20, 16'h0};
    {mismatches, nCompared} = 64'h0;
    cfgTab = '{32'h0120_1124, 32'h0014_1222, 32'h0110_1124, 32'h0120_1123,
               32'h0020_1124, 32'h0520_1124, 32'h0920_1124, 32'h0320_1148,
               32'h0120_1148, 32'h0010_2224, 32'h0010_1421, 32'h0010_1321};
    statTab = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08,
                8'h00, 8'h00, 8'h00, 8'h08};
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++)
      rdchk(IdxDelA + 12'(i), 32'h0, "reset value");
    rdchk(IdxConfig, CfgReset, "config reset");
    rdchk(IdxStatus, 32'h0, "status reset");
    wr(12'h311, 32'hffff_ffff);
    rdchk(12'h311, 32'h0, "unmapped");
    wb(1'b1, IdxDelA, 4'he, 32'h55, rdv);
    rdchk(IdxDelA, 32'h0, "byte lane");
    wr(IdxVarA, 32'hffff_ff05);
    rdchk(IdxVarA, 32'h05, "upper bits");
    for (int i = 0; i < 12; i++) begin
      wr(IdxConfig, cfgTab[i]);
      rdchk(IdxStatus, {24'h0, statTab[i]}, "cfg flags");
    end
    wr(IdxConfig, CfgReset);
    wr(IdxDelA, 32'h20);
    rdchk(IdxStatus, 32'h20, "delay flag");
    wr(IdxDelA, 32'h1f);
    rdchk(IdxStatus, 32'h0, "delay in range");
    helper(3'h2, 6'h20, 8'd30, 8'd34, 8'd26, 8'd6);
    helper(3'h2, 6'h10, 8'd4, 8'd9, 8'd6, 8'd7);
    helper(3'h1, 6'h20, 8'd3, 8'd3, 8'd8, 8'd2);
    set_regs(8'd0, 8'd0, 8'd0);
    run_link(1'b1, lat, h0);
    check({31'h0, lat < Pcyc}, 32'h1, "latency range");
    rdchk(IdxLat0, 32'(lat), "latency readback");
    wr(IdxLat0, 32'hff);
    rdchk(IdxLat0, 32'(lat), "latency read only");
    edge_off(0, o0);
    edge_off(1, o1);
    set_regs(8'd8, 8'd20, 8'd0);
    run_link(1'b0, lat, hN);
    edge_off(0, p0);
    edge_off(1, p1);
    check(32'((p0 - o0 + Pcyc) % Pcyc), 32'd2, "edge shift 0");
    check(32'((p1 - o1 + Pcyc) % Pcyc), 32'd5, "edge shift 1");
    set_regs(8'd0, 8'd0, 8'd5);
    run_link(1'b1, lat, hN);
    check(32'(hN - h0), 32'd5, "buffer delay");
    set_regs(8'd0, 8'd0, 8'd10);
    run_link(1'b1, lat, hN);
    check(32'(hN - h0), 32'd10, "max buffer delay");
    set_regs(8'd0, 8'd0, 8'd12);
    run_link(1'b1, lat, hN);
    check(32'(hN - h0), 32'd10, "clamped delay");
    final_report;
  end
endmodule // tb
`default_nettype wire
